// ### logic/rgm_release_gate.sv
// Release gate: restart lock, pulse check, mute, bypass and error handling
`timescale 1ns/1ps
module rgm_release_gate
    import rgm_pkg::*;
#(
    parameter int NREL = RGM_NREL,
    parameter longint DEB_CYC = RGM_DEB_CYC,
    parameter longint PULSE_MAX_CYC = RGM_PULSE_MAX_CYC,
    parameter longint CYC_PER_S = RGM_CYC_PER_S,
    parameter longint CYC_PER_MIN = RGM_CYC_PER_MIN
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CFG_MANUAL_RESTART,
    input wire logic CFG_MANUAL_RESET,
    input wire logic CFG_MUTE_EN,
    input wire logic CFG_MUTE_LIMIT_EN,
    input wire logic [15:0] CFG_MUTE_TIME_S,
    input wire logic CFG_BYP_EN,
    input wire logic CFG_BYP_LIMIT_EN,
    input wire logic [15:0] CFG_BYP_TIME_MIN,
    input wire logic CFG_WARN_DISABLES,
    input wire logic [NREL-1:0] EVAL_OK,
    input wire logic SENSOR_FAULT,
    input wire logic RANGE_WARN,
    input wire logic RESTART_IN,
    input wire logic ERR_RESET_IN,
    input wire logic MUTE_IN,
    input wire logic BYPASS_IN,
    output logic [NREL-1:0] RELEASE,
    output logic [NREL-1:0] RESTART_PENDING,
    output logic MUTE_ACTIVE,
    output logic BYPASS_ACTIVE,
    output logic RESET_PENDING,
    output logic ERROR_ACTIVE
);
    typedef struct packed {
        logic [1:0] rs_sync;
        logic [1:0] er_sync;
        logic [1:0] mu_sync;
        logic [1:0] by_sync;
        logic rs_prev;
        logic er_prev;
        logic mu_prev;
        logic by_prev;
        logic armed;
        logic [1:0] arm_cnt;
        logic [31:0] rs_cnt;
        logic [31:0] er_cnt;
        logic rs_valid;
        logic er_valid;
        logic mute;
        logic byp;
        logic [NREL-1:0] held;
        logic [NREL-1:0] confirmed;
        logic err;
        logic [47:0] tmr_mu;
        logic [47:0] tmr_by;
        logic [NREL-1:0] rel;
        logic [NREL-1:0] pend;
    } rgm_state_t;

    rgm_state_t st_reg;
    rgm_state_t st_next;

    logic rs_s;
    logic er_s;
    logic mu_s;
    logic by_s;
    logic cause;
    logic err_now;
    logic mu_expire;
    logic by_expire;
    logic [47:0] mu_lim;
    logic [47:0] by_lim;
    logic [15:0] mu_sec;
    logic [15:0] by_min;
    logic [NREL-1:0] base;

    assign rs_s = st_reg.rs_sync[1];
    assign er_s = st_reg.er_sync[1];
    assign mu_s = st_reg.mu_sync[1];
    assign by_s = st_reg.by_sync[1];

    // Clamp configured limits to their maxima
    assign mu_sec = (CFG_MUTE_TIME_S > 16'(RGM_MUTE_MAX_S)) ? 16'(RGM_MUTE_MAX_S)
                    : CFG_MUTE_TIME_S;
    assign by_min = (CFG_BYP_TIME_MIN > 16'(RGM_BYP_MAX_MIN)) ? 16'(RGM_BYP_MAX_MIN)
                    : CFG_BYP_TIME_MIN;
    assign mu_lim = 48'(longint'(mu_sec) * CYC_PER_S);
    assign by_lim = 48'(longint'(by_min) * CYC_PER_MIN);
    assign mu_expire = st_reg.mute && CFG_MUTE_LIMIT_EN && (st_reg.tmr_mu >= mu_lim);
    assign by_expire = st_reg.byp && CFG_BYP_LIMIT_EN && (st_reg.tmr_by >= by_lim);

    assign cause = SENSOR_FAULT || (CFG_WARN_DISABLES && RANGE_WARN);

    always_comb begin
        st_next = st_reg;
        st_next.rs_sync = {st_reg.rs_sync[0], RESTART_IN};
        st_next.er_sync = {st_reg.er_sync[0], ERR_RESET_IN};
        st_next.mu_sync = {st_reg.mu_sync[0], MUTE_IN};
        st_next.by_sync = {st_reg.by_sync[0], BYPASS_IN};
        st_next.rs_prev = rs_s;
        st_next.er_prev = er_s;
        st_next.mu_prev = mu_s;
        st_next.by_prev = by_s;
        // Arm only once the synchronisers and edge registers hold real pin levels,
        // so a pin already high at reset release never looks like a rising edge
        if (st_reg.arm_cnt != 2'h3) begin
            st_next.arm_cnt = st_reg.arm_cnt + 2'h1;
        end
        st_next.armed = st_reg.armed || (st_reg.arm_cnt == 2'h2);
        st_next.rs_valid = 1'b0;
        st_next.er_valid = 1'b0;

        // Pulse width measurement; counts only highs that began from a seen low
        if (!st_reg.armed) begin
            st_next.rs_cnt = 32'h0000_0000;
            st_next.er_cnt = 32'h0000_0000;
        end else begin
            if (rs_s && !st_reg.rs_prev) begin
                st_next.rs_cnt = 32'h0000_0001;
            end else if (rs_s && st_reg.rs_cnt != 32'h0000_0000
                         && st_reg.rs_cnt != 32'hFFFF_FFFF) begin
                st_next.rs_cnt = st_reg.rs_cnt + 32'h0000_0001;
            end else if (!rs_s) begin
                st_next.rs_cnt = 32'h0000_0000;
                st_next.rs_valid = st_reg.rs_prev && (longint'(st_reg.rs_cnt) >= DEB_CYC)
                    && (longint'(st_reg.rs_cnt) <= PULSE_MAX_CYC);
            end
            if (er_s && !st_reg.er_prev) begin
                st_next.er_cnt = 32'h0000_0001;
            end else if (er_s && st_reg.er_cnt != 32'h0000_0000
                         && st_reg.er_cnt != 32'hFFFF_FFFF) begin
                st_next.er_cnt = st_reg.er_cnt + 32'h0000_0001;
            end else if (!er_s) begin
                st_next.er_cnt = 32'h0000_0000;
                st_next.er_valid = st_reg.er_prev && (longint'(st_reg.er_cnt) >= DEB_CYC)
                    && (longint'(st_reg.er_cnt) <= PULSE_MAX_CYC);
            end
        end

        // Error latch
        if (cause) begin
            st_next.err = 1'b1;
        end else if (!CFG_MANUAL_RESET || st_reg.er_valid) begin
            st_next.err = 1'b0;
        end
        err_now = st_next.err;

        // Mute: edge only, so a high at start never triggers it
        if (!CFG_MUTE_EN || (st_reg.mute && (!mu_s || mu_expire))) begin
            st_next.mute = 1'b0;
            st_next.held = '0;
        end else if (st_reg.armed && mu_s && !st_reg.mu_prev && !st_reg.mute) begin
            st_next.mute = 1'b1;
            st_next.held = st_reg.rel;
            st_next.tmr_mu = 48'h0000_0000_0000;
        end else if (st_reg.mute) begin
            st_next.tmr_mu = st_reg.tmr_mu + 48'h0000_0000_0001;
        end

        if (!CFG_BYP_EN || (st_reg.byp && (!by_s || by_expire))) begin
            st_next.byp = 1'b0;
        end else if (st_reg.armed && by_s && !st_reg.by_prev && !st_reg.byp) begin
            st_next.byp = 1'b1;
            st_next.tmr_by = 48'h0000_0000_0000;
        end else if (st_reg.byp) begin
            st_next.tmr_by = st_reg.tmr_by + 48'h0000_0000_0001;
        end

        // Restart lock per release
        for (int i = 0; i < NREL; i++) begin
            if (!CFG_MANUAL_RESTART) begin
                st_next.confirmed[i] = EVAL_OK[i];
            end else if (!EVAL_OK[i] && !(st_reg.byp && st_reg.confirmed[i])) begin
                st_next.confirmed[i] = 1'b0;
            end else if (st_reg.rs_valid && !st_reg.confirmed[i]
                         && (st_reg.pend[i] || st_reg.byp)) begin
                st_next.confirmed[i] = 1'b1;
            end
            // Already confirmed: further restart pulses change nothing
        end
        base = st_next.confirmed & EVAL_OK;
        if (CFG_MANUAL_RESTART) begin
            base = st_next.confirmed & (EVAL_OK | {NREL{st_next.byp}});
        end
        // Muting holds only those already high at the edge
        st_next.rel = err_now ? '0 :
            (base | (st_next.held & {NREL{st_next.mute}}) | {NREL{st_next.byp}});
        st_next.pend = (CFG_MANUAL_RESTART && !err_now) ?
            (EVAL_OK & ~st_next.confirmed) : '0;
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign RELEASE = st_reg.rel;
    assign RESTART_PENDING = st_reg.pend;
    assign MUTE_ACTIVE = st_reg.mute;
    assign BYPASS_ACTIVE = st_reg.byp;
    assign ERROR_ACTIVE = st_reg.err;
    assign RESET_PENDING = st_reg.err && !cause && CFG_MANUAL_RESET;

    property p_fault_drops;
        @(posedge CLK_SYS) disable iff (RST) SENSOR_FAULT |=> (RELEASE == '0);
    endproperty
    a_fault_drops: assert property (p_fault_drops) else $error("release high under fault");

    property p_auto_no_pend;
        @(posedge CLK_SYS) disable iff (RST)
            !CFG_MANUAL_RESTART && !$past(CFG_MANUAL_RESTART) |-> RESTART_PENDING == '0;
    endproperty
    a_auto_no_pend: assert property (p_auto_no_pend) else $error("pending in auto mode");

    property p_byp_forces;
        @(posedge CLK_SYS) disable iff (RST) BYPASS_ACTIVE && !ERROR_ACTIVE |-> &RELEASE;
    endproperty
    a_byp_forces: assert property (p_byp_forces) else $error("bypass not forcing");

    property p_mute_edge;
        @(posedge CLK_SYS) disable iff (RST)
            $rose(MUTE_ACTIVE) |-> $past(st_reg.mu_prev) == 1'b0 && $past(mu_s);
    endproperty
    a_mute_edge: assert property (p_mute_edge) else $error("mute without rising edge");

    property p_mute_ends;
        @(posedge CLK_SYS) disable iff (RST) MUTE_ACTIVE && !mu_s |=> !MUTE_ACTIVE;
    endproperty
    a_mute_ends: assert property (p_mute_ends) else $error("mute did not end");

    property p_byp_ends;
        @(posedge CLK_SYS) disable iff (RST) BYPASS_ACTIVE && by_expire |=> !BYPASS_ACTIVE;
    endproperty
    a_byp_ends: assert property (p_byp_ends) else $error("bypass limit ignored");

    property p_short_reject;
        @(posedge CLK_SYS) disable iff (RST)
            st_reg.rs_valid |-> $past(longint'(st_reg.rs_cnt)) >= DEB_CYC;
    endproperty
    a_short_reject: assert property (p_short_reject) else $error("short pulse accepted");

    property p_long_reject;
        @(posedge CLK_SYS) disable iff (RST)
            st_reg.rs_valid |-> $past(longint'(st_reg.rs_cnt)) <= PULSE_MAX_CYC;
    endproperty
    a_long_reject: assert property (p_long_reject) else $error("long pulse accepted");

    property p_pend_excl;
        @(posedge CLK_SYS) disable iff (RST) (RESTART_PENDING & RELEASE & ~{NREL{BYPASS_ACTIVE}}
            & ~{NREL{MUTE_ACTIVE}}) == '0;
    endproperty
    a_pend_excl: assert property (p_pend_excl) else $error("pending with release");

    property p_byp_edge;
        @(posedge CLK_SYS) disable iff (RST)
            $rose(BYPASS_ACTIVE) |-> $past(st_reg.by_prev) == 1'b0 && $past(by_s);
    endproperty
    a_byp_edge: assert property (p_byp_edge) else $error("bypass without rising edge");

    property p_start_quiet;
        @(posedge CLK_SYS) disable iff (RST) !st_reg.armed |=> !MUTE_ACTIVE && !BYPASS_ACTIVE;
    endproperty
    a_start_quiet: assert property (p_start_quiet) else $error("edge taken before arming");

    property p_err_held;
        @(posedge CLK_SYS) disable iff (RST)
            ERROR_ACTIVE && CFG_MANUAL_RESET && !st_reg.er_valid |=> ERROR_ACTIVE;
    endproperty
    a_err_held: assert property (p_err_held) else $error("error cleared without reset");

    property p_pend_drop;
        @(posedge CLK_SYS) disable iff (RST) (RESTART_PENDING & ~$past(EVAL_OK)) == '0;
    endproperty
    a_pend_drop: assert property (p_pend_drop) else $error("pending without condition");

    c_restart: cover property (@(posedge CLK_SYS) disable iff (RST)
        $rose(RELEASE[0]) && CFG_MANUAL_RESTART);
    c_mute_limit: cover property (@(posedge CLK_SYS) disable iff (RST)
        $fell(MUTE_ACTIVE) && mu_s);
    c_mute: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(MUTE_ACTIVE));
    c_bypass: cover property (@(posedge CLK_SYS) disable iff (RST) $fell(BYPASS_ACTIVE));
    c_err_reset: cover property (@(posedge CLK_SYS) disable iff (RST) $fell(ERROR_ACTIVE));
endmodule : rgm_release_gate

// ### logic/rgm_pkg.sv
// Constants for the release gate with restart, mute and bypass
package rgm_pkg;
    localparam int RGM_CLK_HZ = 100_000_000;
    localparam int RGM_CYC_PER_MS = RGM_CLK_HZ / 1000;
    localparam int RGM_DEB_MS = 100;
    localparam int RGM_DEB_CYC = RGM_DEB_MS * RGM_CYC_PER_MS;
    localparam int RGM_PULSE_MAX_S = 30;
    localparam longint RGM_PULSE_MAX_CYC = longint'(RGM_PULSE_MAX_S) * RGM_CLK_HZ;
    localparam int RGM_MUTE_MAX_S = 7200;
    localparam int RGM_BYP_MAX_MIN = 600;
    localparam longint RGM_CYC_PER_S = longint'(RGM_CLK_HZ);
    localparam longint RGM_CYC_PER_MIN = 60 * longint'(RGM_CLK_HZ);
    localparam int RGM_NREL = 4;
    localparam logic [15:0] RGM_TIME_RST = 16'h0000;
endpackage : rgm_pkg

// ### bench/rgm_operator.sv
// Operator model: shapes low-high-low command pulses on one pin
`timescale 1ns/1ps
module rgm_operator (
    input wire logic clk,
    input wire logic go,
    input wire logic hold,
    input wire logic [15:0] len,
    output logic pin
);
    logic [15:0] left_reg = 16'h0000;
    // High phase lasts exactly len cycles, then the pin returns low
    always @(negedge clk) begin
        if (go) begin
            left_reg <= len;
        end else if (left_reg != 16'h0000) begin
            left_reg <= left_reg - 16'h0001;
        end
    end
    // Hold keeps the pin high through reset release, so only its fall is seen
    assign pin = hold | (left_reg != 16'h0000);
endmodule : rgm_operator

// ### bench/rgm_release_gate_bench.sv
// Bench for the release gate: restart, mute, bypass and error sequences
`timescale 1ns/1ps
module rgm_release_gate_bench;
    localparam logic [11:0] M_RP = 12'hFF0;
    logic clk;
    logic rst = 1'b1;
    logic man = 1'b1, man_rsv = 1'b0, mute_en = 1'b1, mute_lim = 1'b0;
    logic byp_en = 1'b1, byp_lim = 1'b0, warn_dis = 1'b0;
    logic [15:0] mute_t = 16'h0003, byp_t = 16'h0002, op_len = 16'h0000;
    logic [3:0] eval = 4'h0;
    logic fault = 1'b0, warn = 1'b0, mute_in = 1'b1, byp_in = 1'b1, rs_hold = 1'b1;
    logic [1:0] op_go = 2'b00;
    logic restart_pin, reset_pin, mute_act, byp_act, rst_pend, err_act;
    logic [3:0] rel, pend;
    logic [11:0] st;
    int failures = 0;
    int n_compared = 0;
    assign st = {rel, pend, mute_act, byp_act, rst_pend, err_act};

    rgm_release_gate #(.DEB_CYC(20), .PULSE_MAX_CYC(200), .CYC_PER_S(10), .CYC_PER_MIN(10))
    rgm_release_gate_inst (
        .CLK_SYS(clk), .RST(rst), .CFG_MANUAL_RESTART(man), .CFG_MANUAL_RESET(man_rsv),
        .CFG_MUTE_EN(mute_en), .CFG_MUTE_LIMIT_EN(mute_lim), .CFG_MUTE_TIME_S(mute_t),
        .CFG_BYP_EN(byp_en), .CFG_BYP_LIMIT_EN(byp_lim), .CFG_BYP_TIME_MIN(byp_t),
        .CFG_WARN_DISABLES(warn_dis), .EVAL_OK(eval), .SENSOR_FAULT(fault),
        .RANGE_WARN(warn), .RESTART_IN(restart_pin), .ERR_RESET_IN(reset_pin),
        .MUTE_IN(mute_in), .BYPASS_IN(byp_in), .RELEASE(rel), .RESTART_PENDING(pend),
        .MUTE_ACTIVE(mute_act), .BYPASS_ACTIVE(byp_act), .RESET_PENDING(rst_pend),
        .ERROR_ACTIVE(err_act));
    rgm_operator restart_op (.clk(clk), .go(op_go[0]), .hold(rs_hold), .len(op_len),
        .pin(restart_pin));
    rgm_operator reset_op (.clk(clk), .go(op_go[1]), .hold(1'b0), .len(op_len),
        .pin(reset_pin));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic report_and_stop;
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step

    // Waits up to bound cycles for the masked status; a miss ends the run unless bound is zero
    task automatic chk(input logic [11:0] exp, input logic [11:0] msk, input int bound,
        input string what);
        int i = 0;
        while ((st & msk) !== exp && i < bound) begin
            @(negedge clk);
            i++;
        end
        n_compared++;
        if ((st & msk) !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, st & msk);
            failures++;
            if (bound != 0) report_and_stop();
        end
    endtask : chk

    task automatic pulse(input int which, input int len);
        @(negedge clk);
        op_len <= len[15:0];
        op_go[which] <= 1'b1;
        @(negedge clk);
        op_go <= 2'b00;
        step(len + 10);
    endtask : pulse

    initial begin
        step(5);
        rst = 1'b0;
        step(10);
        chk(12'h000, 12'hFFF, 0, "idle");
        mute_in = 1'b0;
        byp_in = 1'b0;
        rs_hold = 1'b0;
        eval = 4'hF;
        step(12);
        chk(12'h0F0, M_RP, 0, "pend");
        pulse(0, 10);
        chk(12'h0F0, M_RP, 0, "short");
        pulse(0, 250);
        chk(12'h0F0, M_RP, 0, "long");
        pulse(0, 40);
        chk(12'hF00, M_RP, 0, "accept");
        pulse(0, 40);
        chk(12'hF00, M_RP, 0, "again");
        eval = 4'hE;
        chk(12'hE00, M_RP, 8, "drop");
        eval = 4'hF;
        chk(12'hE10, M_RP, 8, "repend");
        eval = 4'hE;
        chk(12'hE00, M_RP, 8, "unpend");
        eval = 4'hF;
        pulse(0, 40);
        chk(12'hF00, M_RP, 8, "bit0");
        mute_in = 1'b1;
        chk(12'hF08, 12'hF08, 5, "mute on");
        eval = 4'h0;
        step(10);
        chk(12'hF08, 12'hF08, 0, "held");
        mute_in = 1'b0;
        chk(12'h000, 12'hFF8, 6, "mute off");
        man = 1'b0;
        mute_in = 1'b1;
        chk(12'h008, 12'hFF8, 5, "mute 2");
        eval = 4'h2;
        chk(12'h208, 12'hFF8, 5, "auto rel");
        eval = 4'h0;
        chk(12'h008, 12'hFF8, 5, "not held");
        mute_in = 1'b0;
        mute_lim = 1'b1;
        eval = 4'hF;
        step(5);
        mute_in = 1'b1;
        chk(12'hF08, 12'hFF8, 5, "mute 3");
        eval = 4'h0;
        step(20);
        chk(12'hF08, 12'hF08, 0, "limit hold");
        chk(12'h000, 12'hF08, 20, "expire");
        mute_in = 1'b0;
        step(5);
        byp_in = 1'b1;
        chk(12'hF04, 12'hF04, 5, "byp on");
        byp_in = 1'b0;
        chk(12'h000, 12'hF04, 6, "byp off");
        byp_lim = 1'b1;
        step(2);
        byp_in = 1'b1;
        chk(12'hF04, 12'hF04, 5, "byp 2");
        step(10);
        chk(12'hF04, 12'hF04, 0, "byp hold");
        chk(12'h000, 12'hF04, 20, "byp end");
        byp_in = 1'b0;
        byp_lim = 1'b0;
        man = 1'b1;
        eval = 4'hF;
        step(5);
        byp_in = 1'b1;
        chk(12'hF04, 12'hF04, 5, "bridge");
        pulse(0, 40);
        byp_in = 1'b0;
        step(8);
        chk(12'hF00, 12'hFF4, 0, "latched");
        man = 1'b0;
        fault = 1'b1;
        chk(12'h001, 12'hF01, 5, "fault");
        fault = 1'b0;
        chk(12'hF00, 12'hF03, 5, "auto clear");
        man_rsv = 1'b1;
        fault = 1'b1;
        chk(12'h001, 12'hF01, 5, "fault 2");
        fault = 1'b0;
        chk(12'h002, 12'hF02, 5, "rst pend");
        pulse(1, 40);
        chk(12'hF00, 12'hF03, 5, "reset");
        man_rsv = 1'b0;
        warn_dis = 1'b1;
        warn = 1'b1;
        chk(12'h000, 12'hF00, 5, "warn");
        warn = 1'b0;
        chk(12'hF00, 12'hF00, 5, "warn clr");
        warn_dis = 1'b0;
        warn = 1'b1;
        step(8);
        chk(12'hF00, 12'hF00, 0, "warn kept");
        report_and_stop();
    end
endmodule : rgm_release_gate_bench
